// ### pkg/slc_pkg.sv
// Package: register map, field positions, reset values and timing constants of the segment LCD controller
package slc_pkg;

  // ----------------------------------------------------------------
  // Register indices (printed offsets are not all multiples of four)
  // ----------------------------------------------------------------
  localparam logic [15:0] PANEL_PORT_CONTROL_IDX = 16'hFFC0; // Duty and common duplication
  localparam logic [15:0] PANEL_CONTROL_IDX      = 16'hFFC1; // Run, supply, display, clock select
  localparam logic [15:0] PANEL_CONTROL_TWO_IDX  = 16'hFFC2; // Waveform type select
  localparam logic [15:0] DISPLAY_MEMORY_IDX     = 16'hF740; // First display memory byte
  localparam int          DISPLAY_MEMORY_BYTES   = 16;       // Display memory size in bytes
  localparam int          ADDR_W                 = 18;       // Byte address width (index times four)

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PC_SUPPLY_BIT = 6; // supply_divider_connect
  localparam int PC_RUN_BIT    = 5; // controller_run
  localparam int PC_SHOW_BIT   = 4; // show_ram_contents
  localparam int PC_CKS_LSB    = 0; // frame_clock_select low bit, four bits wide
  localparam int PC2_WAVE_BIT  = 7; // waveform_type_select
  localparam int PPC_DUTY_LSB  = 6; // duty_select_lo; duty_select_hi is bit 7
  localparam int PPC_CMX_BIT   = 5; // common_duplicate

  // ----------------------------------------------------------------
  // Reset values (the documented operating settings)
  // ----------------------------------------------------------------
  localparam logic [7:0] PANEL_CONTROL_RST      = 8'h3E; // Run=1, show=1, clock code 1110
  localparam logic [7:0] PANEL_CONTROL_TWO_RST  = 8'h00; // Waveform A
  localparam logic [7:0] PANEL_PORT_CONTROL_RST = 8'hC0; // 1/4 duty, no duplication
  localparam logic [7:0] PANEL_CONTROL_TWO_MASK = 8'h80; // Only bit 7 implemented
  localparam logic [7:0] PANEL_PORT_CTRL_MASK   = 8'hE0; // Duty and duplicate bits only

  // ----------------------------------------------------------------
  // Clock select codes and duty codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CKS_DIV128 = 4'hE; // System clock divided by 128
  localparam logic [1:0] DUTY_QUART = 2'h3; // 1/4 duty
  localparam logic [1:0] DUTY_THIRD = 2'h2; // 1/3 duty
  localparam logic [1:0] DUTY_HALF  = 2'h1; // 1/2 duty
  localparam logic [1:0] DUTY_STAT  = 2'h0; // Static drive
  localparam int         NUM_COMMON = 4;    // Common lines on the panel
  localparam int         NUM_SEG    = 32;   // Segment lines on the panel

endpackage

// ### logic/slc_prescaler.sv
// Prescaler: divides the system clock by a power of two chosen by the frame clock select code
`timescale 1ns/1ps
module slc_prescaler #(
  parameter int DIV_W = 12
) (
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       run,
  input  wire logic [3:0] cks,
  output logic            tick
);

  // ----------------------------------------------------------------
  // Divider counter
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] cnt_reg;  // Free count while running
  logic [DIV_W-1:0] cnt_next; // Next count
  logic [DIV_W-1:0] mask;     // Low bits that must all be ones for a tick
  logic [3:0]       shift;    // Divide exponent

  // The largest divide exponent is 8, so the count needs at least 8 bits
  if (DIV_W < 8)
  begin : g_width_check
    $error("slc_prescaler: DIV_W too small");
  end

  // Code 1110 is divide by 128 (exponent 7); codes from 0111 up map linearly around it, lower codes give exponent 0
  assign shift    = (cks >= 4'h7) ? 4'(cks - 4'h7) : 4'h0;
  assign mask     = DIV_W'((1 << shift) - 1);
  assign cnt_next = run ? DIV_W'(cnt_reg + 1'b1) : '0;
  assign tick     = run && ((cnt_reg & mask) == mask);

  // Counter held at zero when stopped so a restart begins cleanly
  always_ff @(posedge mclk)
  begin
    if (srst)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end

endmodule

// ### logic/slc_ctrl.sv
// Segment LCD controller control logic with APB register access
`timescale 1ns/1ps
// Function
// - Supply divider follows supply_divider_connect bit
// - Run low forces supply divider off
// - Run low stops all panel operation
// - Clearing run keeps all register contents
// - Show bit low drives blank data
// - Clock select field picks frame rate
// - Waveform select bit picks type A/B
// - Duty field selects static to quarter duty
// - Duplicate bit copies waveform to unused commons
module slc_ctrl (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        standby,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             divider_connect,
  output logic             drive_enable,
  output logic             waveform_b,
  output logic [3:0]       com_active,
  output logic [3:0]       com_phase_level,
  output logic [31:0]      seg_data
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  localparam logic [17:0] A_PC   = {slc_pkg::PANEL_CONTROL_IDX, 2'b00};
  localparam logic [17:0] A_PC2  = {slc_pkg::PANEL_CONTROL_TWO_IDX, 2'b00};
  localparam logic [17:0] A_PPC  = {slc_pkg::PANEL_PORT_CONTROL_IDX, 2'b00};
  localparam logic [17:0] A_MEM  = {slc_pkg::DISPLAY_MEMORY_IDX, 2'b00};
  localparam logic [17:0] A_MEND = 18'(A_MEM + 18'(4 * slc_pkg::DISPLAY_MEMORY_BYTES));

  wire access  = psel && penable;            // Access phase
  wire wr_en   = access && pwrite;           // Write strobe
  wire hit_pc  = (paddr == A_PC);            // panel_control
  wire hit_pc2 = (paddr == A_PC2);           // panel_control_two
  wire hit_ppc = (paddr == A_PPC);           // panel_port_control
  wire hit_mem = (paddr >= A_MEM) && (paddr < A_MEND) && (paddr[1:0] == 2'b00);
  wire hit_any = hit_pc || hit_pc2 || hit_ppc || hit_mem;
  wire [3:0] mem_idx = paddr[5:2];           // Display memory byte index

  // Zero wait state; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = access && !hit_any;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [7:0] pc_reg;  // panel_control
  logic [7:0] pc2_reg; // panel_control_two
  logic [7:0] ppc_reg; // panel_port_control

  // Registers change only on bus writes; run clearing touches nothing
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      pc_reg  <= slc_pkg::PANEL_CONTROL_RST;
      pc2_reg <= slc_pkg::PANEL_CONTROL_TWO_RST;
      ppc_reg <= slc_pkg::PANEL_PORT_CONTROL_RST;
    end
    else if (wr_en)
    begin
      if (hit_pc)
        pc_reg <= {1'b0, pwdata[6:0]};
      if (hit_pc2)
        pc2_reg <= pwdata[7:0] & slc_pkg::PANEL_CONTROL_TWO_MASK;
      if (hit_ppc)
        ppc_reg <= pwdata[7:0] & slc_pkg::PANEL_PORT_CTRL_MASK;
    end
  end

  wire       run      = pc_reg[slc_pkg::PC_RUN_BIT];
  wire       sup_bit  = pc_reg[slc_pkg::PC_SUPPLY_BIT];
  wire       show     = pc_reg[slc_pkg::PC_SHOW_BIT];
  wire [3:0] cks      = pc_reg[slc_pkg::PC_CKS_LSB +: 4];
  wire [1:0] duty     = ppc_reg[slc_pkg::PPC_DUTY_LSB +: 2];
  wire       dup      = ppc_reg[slc_pkg::PPC_CMX_BIT];
  wire       active   = run && !standby;    // Operating only when run and awake

  // ----------------------------------------------------------------
  // Display memory
  // ----------------------------------------------------------------
  logic [7:0] mem_reg [slc_pkg::DISPLAY_MEMORY_BYTES]; // Segment pattern, written by software

  // One write port per byte, written only by software
  for (genvar i = 0; i < slc_pkg::DISPLAY_MEMORY_BYTES; i++)
  begin : g_mem
    always_ff @(posedge mclk)
    begin
      if (srst)
        mem_reg[i] <= 8'h00;
      else if (wr_en && hit_mem && (mem_idx == 4'(i)))
        mem_reg[i] <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [7:0] rd_byte = hit_pc  ? pc_reg  :
                       hit_pc2 ? pc2_reg :
                       hit_ppc ? ppc_reg :
                       hit_mem ? mem_reg[mem_idx] : 8'h00;
  logic [7:0] rdata_reg; // Read byte captured in the setup cycle

  // Captured while the address is set up, so the access cycle needs no wait state
  always_ff @(posedge mclk)
  begin
    if (srst)
      rdata_reg <= 8'h00;
    else if (psel && !penable)
      rdata_reg <= rd_byte;
  end

  assign prdata = {24'h000000, rdata_reg};

  // ----------------------------------------------------------------
  // Frame clock and common scan
  // ----------------------------------------------------------------
  logic tick; // One pulse per common phase

  slc_prescaler #(
    .DIV_W (12)
  ) u_pre (
    .mclk  (mclk),
    .srst  (srst),
    .run   (active),
    .cks   (cks),
    .tick  (tick)
  );

  logic [1:0] phase_reg;  // Current common phase
  logic [1:0] phase_next; // Next phase
  wire  [1:0] last_phase = (duty == slc_pkg::DUTY_STAT) ? 2'd0 :
                           (duty == slc_pkg::DUTY_HALF) ? 2'd1 :
                           (duty == slc_pkg::DUTY_THIRD) ? 2'd2 : 2'd3;

  // A phase left beyond a newly shortened duty restarts at once instead of waiting a tick
  assign phase_next = !active ? 2'd0 :
                      (phase_reg > last_phase) ? 2'd0 :
                      !tick ? phase_reg :
                      (phase_reg >= last_phase) ? 2'd0 : 2'(phase_reg + 1'b1);

  // Phase scan halts and resets when the controller is stopped
  always_ff @(posedge mclk)
  begin
    if (srst)
      phase_reg <= 2'd0;
    else
      phase_reg <= phase_next;
  end

  // ----------------------------------------------------------------
  // Segment fetch: each phase reads one bit from each nibble of every byte
  // ----------------------------------------------------------------
  logic [31:0] seg_reg;  // Segment levels latched for the current phase
  logic [31:0] seg_next; // Levels built from memory

  // Segment n uses byte n/2 nibble (n%2); bit chosen by the common phase
  for (genvar s = 0; s < slc_pkg::NUM_SEG; s++)
  begin : g_seg
    assign seg_next[s] = mem_reg[s/2][(s%2)*4 + int'(phase_next)];
  end

  // Latched on each phase tick; blank when display disabled or stopped
  always_ff @(posedge mclk)
  begin
    if (srst)
      seg_reg <= 32'h00000000;
    else if (!active || !show)
      seg_reg <= 32'h00000000;
    else if (tick || (phase_reg == 2'd0 && seg_reg == 32'h00000000))
      seg_reg <= seg_next;
  end

  assign seg_data = seg_reg;

  // ----------------------------------------------------------------
  // Panel drive outputs
  // ----------------------------------------------------------------
  logic [3:0] com_act_reg; // Commons driven this duty
  logic [3:0] com_lvl_reg; // Which common is selected now
  logic       conn_reg;    // Divider switch
  logic       drv_reg;     // Drive supply on
  logic       wave_reg;    // Waveform B selected

  logic [3:0] lvl_one;     // Selected common alone
  logic [3:0] lvl_dup;     // Selected common and its copies on unused commons

  // Common c repeats the waveform of common c mod (last phase + 1), so every unused pin gets a copy
  for (genvar c = 0; c < slc_pkg::NUM_COMMON; c++)
  begin : g_com
    assign lvl_one[c] = (phase_next == 2'(c));
    assign lvl_dup[c] = ((c % (int'(last_phase) + 1)) == int'(phase_next));
  end

  // Commons beyond the duty are parked unless duplication is on
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      com_act_reg <= 4'h0;
      com_lvl_reg <= 4'h0;
      conn_reg    <= 1'b0;
      drv_reg     <= 1'b0;
      wave_reg    <= 1'b0;
    end
    else
    begin
      conn_reg    <= active && sup_bit;
      drv_reg     <= active;
      wave_reg    <= pc2_reg[slc_pkg::PC2_WAVE_BIT];
      com_act_reg <= !active ? 4'h0 : dup ? 4'hF : 4'((5'h02 << last_phase) - 5'h01);
      com_lvl_reg <= !active ? 4'h0 :
                     dup ? lvl_dup :
                     lvl_one;
    end
  end

  assign divider_connect = conn_reg;
  assign drive_enable    = drv_reg;
  assign waveform_b      = wave_reg;
  assign com_active      = com_act_reg;
  assign com_phase_level = com_lvl_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_divider_off;
    @(posedge mclk) disable iff (srst) !active |=> !divider_connect;
  endproperty
  a_divider_off: assert property (p_divider_off) else $error("divider on while stopped");

  property p_divider_follow;
    @(posedge mclk) disable iff (srst) active |=> (divider_connect == $past(sup_bit));
  endproperty
  a_divider_follow: assert property (p_divider_follow) else $error("divider not following bit");

  property p_stop_all;
    @(posedge mclk) disable iff (srst) !active ##1 !active |-> !drive_enable && com_active == 4'h0 && seg_data == 0;
  endproperty
  a_stop_all: assert property (p_stop_all) else $error("panel driven while stopped");

  property p_keep_regs;
    @(posedge mclk) disable iff (srst) !wr_en |=> $stable(pc_reg) && $stable(ppc_reg) && $stable(pc2_reg);
  endproperty
  a_keep_regs: assert property (p_keep_regs) else $error("register changed without write");

  property p_blank;
    @(posedge mclk) disable iff (srst) !show |=> seg_data == 32'h00000000;
  endproperty
  a_blank: assert property (p_blank) else $error("segments not blank");

  property p_wave;
    @(posedge mclk) disable iff (srst) ##1 waveform_b == $past(pc2_reg[slc_pkg::PC2_WAVE_BIT]);
  endproperty
  a_wave: assert property (p_wave) else $error("waveform select mismatch");

  property p_phase_limit;
    @(posedge mclk) disable iff (srst) phase_reg <= last_phase || $changed(duty) || $past(duty) != duty;
  endproperty
  a_phase_limit: assert property (p_phase_limit) else $error("phase beyond duty");

  property p_dup_all;
    @(posedge mclk) disable iff (srst) active && dup |=> com_active == 4'hF;
  endproperty
  a_dup_all: assert property (p_dup_all) else $error("duplicate commons not driven");

  property p_phase_tick;
    @(posedge mclk) disable iff (srst) active && !tick && (phase_reg <= last_phase) |=> $stable(phase_reg);
  endproperty
  a_phase_tick: assert property (p_phase_tick) else $error("phase moved without tick");

  // Without duplication exactly one common is selected at a time
  property p_single_common;
    @(posedge mclk) disable iff (srst) active && !dup |=> $onehot(com_phase_level);
  endproperty
  a_single_common: assert property (p_single_common) else $error("more than one common selected");

  property p_common_in_duty;
    @(posedge mclk) disable iff (srst) (com_phase_level & ~com_active) == 4'h0;
  endproperty
  a_common_in_duty: assert property (p_common_in_duty) else $error("selected common not driven");

  property p_run_drive;
    @(posedge mclk) disable iff (srst) active |=> drive_enable;
  endproperty
  a_run_drive: assert property (p_run_drive) else $error("drive off while running");

  c_run_show: cover property (@(posedge mclk) disable iff (srst) active && show && tick);
  c_stop:     cover property (@(posedge mclk) disable iff (srst) $fell(run));
  c_mem_wr:   cover property (@(posedge mclk) disable iff (srst) wr_en && hit_mem);
  c_unmapped: cover property (@(posedge mclk) disable iff (srst) pslverr);
  c_dup_scan: cover property (@(posedge mclk) disable iff (srst) active && dup && tick);

endmodule

// ### verif/slc_panel_model.sv
// Panel model: watches the common scan and measures the spacing of phase changes
`timescale 1ns/1ps
module slc_panel_model (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        drive_enable,
  input  wire logic [3:0]  com_active,
  input  wire logic [3:0]  com_phase_level,
  input  wire logic [31:0] seg_data,
  output logic      [15:0] interval,
  output logic      [15:0] changes
);
  // ----------------------------------------------------------------
  // Phase change timing
  // ----------------------------------------------------------------
  logic [15:0] cnt;            // Cycles since the last common change
  logic [3:0]  last_com;       // Common pattern seen one cycle ago
  logic        lit;            // Panel shows something only while driven
  assign lit = drive_enable && (com_active != 4'h0);
  // A change of the driven common marks one scan step of the panel
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cnt      <= 16'h0000;
      interval <= 16'h0000;
      changes  <= 16'h0000;
      last_com <= 4'h0;
    end
    else
    begin
      last_com <= com_phase_level;
      if (lit && (com_phase_level != last_com))
      begin
        interval <= cnt + 16'h0001;
        changes  <= changes + 16'h0001;
        cnt      <= 16'h0000;
      end
      else
        cnt <= cnt + 16'h0001;
    end
  end
endmodule

// ### verif/slc_ctrl_tb.sv
// Testbench: APB register tests and panel output checks of the segment LCD controller
`timescale 1ns/1ps
module slc_ctrl_tb;
  // ----------------------------------------------------------------
  // Signals and addresses
  // ----------------------------------------------------------------
  logic        mclk, srst, standby, psel, penable, pwrite, pready, pslverr;
  logic        divider_connect, drive_enable, waveform_b;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, seg_data, rd;
  logic [3:0]  com_active, com_phase_level;
  logic [15:0] interval, changes;
  logic        er;
  int          bad_count, tests_run, mx, ix;
  localparam logic [17:0] A_PC  = {slc_pkg::PANEL_CONTROL_IDX, 2'b00};
  localparam logic [17:0] A_PC2 = {slc_pkg::PANEL_CONTROL_TWO_IDX, 2'b00};
  localparam logic [17:0] A_PPC = {slc_pkg::PANEL_PORT_CONTROL_IDX, 2'b00};
  localparam logic [17:0] A_MEM = {slc_pkg::DISPLAY_MEMORY_IDX, 2'b00};
  localparam logic [3:0]  CODES [3] = '{4'h8, 4'hA, 4'hE};
  // ----------------------------------------------------------------
  // Instances and clock
  // ----------------------------------------------------------------
  slc_ctrl slc_ctrl_inst (.mclk(mclk), .srst(srst), .standby(standby), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .divider_connect(divider_connect), .drive_enable(drive_enable), .waveform_b(waveform_b),
    .com_active(com_active), .com_phase_level(com_phase_level), .seg_data(seg_data));
  slc_panel_model slc_panel_model_inst (.mclk(mclk), .srst(srst), .drive_enable(drive_enable),
    .com_active(com_active), .com_phase_level(com_phase_level), .seg_data(seg_data),
    .interval(interval), .changes(changes));
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Compare and count; any difference is reported at once
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // APB transfer: request held until pready is sampled high
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      rd = prdata;
      er = pslverr;
    end while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Bounded wait for the next scan step seen by the panel
  task automatic wait_step();
    logic [15:0] c0;
    c0 = changes;
    for (int i = 0; i < 600 && changes === c0; i++) @(posedge mclk);
    if (changes === c0) chk(32'h0, 32'h1);
  endtask
  // Memory pattern that differs in every byte and nibble
  function automatic logic [7:0] pat(input int i);
    return {i[3:0], ~i[3:0]};
  endfunction
  // Segment s shows memory byte s/2, bit (s%2)*4+phase
  function automatic logic [31:0] exp_seg(input int p);
    logic [31:0] v;
    logic [7:0]  b;
    for (int s = 0; s < 32; s++)
    begin
      b    = pat(s / 2);
      v[s] = b[(s % 2) * 4 + p];
    end
    return v;
  endfunction
  // Duplicated commons repeat the d+1 used commons in turn
  function automatic logic [3:0] dup_lvl(input int d, input int p);
    logic [3:0] v;
    for (int c = 0; c < 4; c++)
      v[c] = ((c % (d + 1)) == p);
    return v;
  endfunction
  function automatic int phase_idx(input logic [3:0] c);
    for (int i = 0; i < 4; i++) if (c[i]) return i;
    return 0;
  endfunction
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Watchdog and test sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (60000) @(posedge mclk);
    bad_count++;
    summarize();
  end
  initial
  begin
    bad_count = 0; tests_run = 0;
    srst = 1'b1; standby = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 18'h00000; pwdata = 32'h00000000;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    // Reset values and an unmapped place
    apb(1'b0, A_PC, 32'h0);  chk(rd, 32'h3E);
    apb(1'b0, A_PC2, 32'h0); chk(rd, 32'h00);
    apb(1'b0, A_PPC, 32'h0); chk(rd, 32'hC0);
    apb(1'b0, 18'h00010, 32'h0); chk({31'h0, er}, 32'h1); chk(rd, 32'h0);
    chk({31'h0, drive_enable}, 32'h1);
    chk({31'h0, divider_connect}, 32'h0);
    // Display memory filled over its whole range
    for (int i = 0; i < slc_pkg::DISPLAY_MEMORY_BYTES; i++) apb(1'b1, A_MEM + 18'(4 * i), {24'h0, pat(i)});
    apb(1'b0, A_MEM + 18'h3C, 32'h0); chk(rd, {24'h0, pat(15)});
    // Frame clock codes set the scan step spacing
    foreach (CODES[k])
    begin
      apb(1'b1, A_PC, {24'h0, 4'h3, CODES[k]});
      wait_step(); wait_step(); wait_step();
      chk({16'h0, interval}, 32'(1 << (CODES[k] - 7)));
    end
    // Segment levels per phase, then blank data
    apb(1'b1, A_PC, 32'h3A);
    for (int n = 0; n < 4; n++)
    begin
      wait_step(); repeat (2) @(posedge mclk);
      chk(seg_data, exp_seg(phase_idx(com_phase_level)));
    end
    apb(1'b1, A_PC, 32'h2A); wait_step(); wait_step();
    chk(seg_data, 32'h0);
    // Supply divider, standby and run control
    apb(1'b1, A_PC, 32'h7A); repeat (3) @(posedge mclk);
    chk({31'h0, divider_connect}, 32'h1);
    standby <= 1'b1; repeat (3) @(posedge mclk);
    chk({30'h0, divider_connect, drive_enable}, 32'h0);
    standby <= 1'b0; repeat (3) @(posedge mclk);
    chk({30'h0, divider_connect, drive_enable}, 32'h3);
    apb(1'b1, A_PC, 32'h5A); repeat (3) @(posedge mclk);
    chk({30'h0, divider_connect, drive_enable}, 32'h0);
    chk({28'h0, com_active}, 32'h0);
    chk(seg_data, 32'h0);
    apb(1'b0, A_PC, 32'h0); chk(rd, 32'h5A);
    apb(1'b0, A_MEM + 18'h0C, 32'h0); chk(rd, {24'h0, pat(3)});
    // Waveform type select, unimplemented bits dropped
    apb(1'b1, A_PC2, 32'hFF); apb(1'b0, A_PC2, 32'h0); chk(rd, 32'h80);
    repeat (2) @(posedge mclk); chk({31'h0, waveform_b}, 32'h1);
    apb(1'b1, A_PC2, 32'h00); repeat (3) @(posedge mclk); chk({31'h0, waveform_b}, 32'h0);
    // Every duty code, with and without common duplication
    apb(1'b1, A_PC, 32'h38);
    for (int d = 0; d < 4; d++)
    begin
      apb(1'b1, A_PPC, 32'(d << 6)); repeat (3) @(posedge mclk);
      chk({28'h0, com_active}, 32'((1 << (d + 1)) - 1));
      mx = 0;
      for (int n = 0; n < 6; n++)
      begin
        if (d > 0)
          wait_step();
        else
          repeat (4) @(posedge mclk);
        ix = phase_idx(com_phase_level);
        if (ix > mx)
          mx = ix;
      end
      chk(32'(mx), 32'(d));
      apb(1'b1, A_PPC, 32'((d << 6) | 8'h20)); repeat (3) @(posedge mclk);
      chk({28'h0, com_active}, 32'hF);
      chk({28'h0, com_phase_level}, {28'h0, dup_lvl(d, phase_idx(com_phase_level))});
    end
    apb(1'b1, A_PPC, 32'hFF); apb(1'b0, A_PPC, 32'h0); chk(rd, 32'hE0);
    summarize();
  end
endmodule
